/* rtl/port_cmd_issue_active_notify.sv */
// Per-port command issue, queued-active and async notification registers behind AXI4-Lite
`timescale 1ns/1ps
`default_nettype none

module port_cmd_issue_active_notify (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  // AXI4-Lite write address
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [7:0] s_axi_awaddr_in,
  // AXI4-Lite write data
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  // AXI4-Lite write response
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  output logic [1:0] s_axi_bresp_out,
  // AXI4-Lite read address
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  input wire logic [7:0] s_axi_araddr_in,
  // AXI4-Lite read data
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  // Received set-device-bits FIS, one-cycle strobe
  input wire logic sdb_valid_in,
  input wire logic [31:0] sdb_sactive_in,
  input wire logic sdb_ok_in,
  input wire logic sdb_notify_in,
  input wire logic [3:0] sdb_pm_port_in,
  // Received FIS clearing busy, data request and error for one slot
  input wire logic slot_done_valid_in,
  input wire logic [4:0] slot_done_idx_in,
  // Register state seen by the rest of the port
  output logic [31:0] tag_outstanding_bits_out,
  output logic [31:0] slot_issued_bits_out,
  output logic port_run_control_out,
  output logic irq_out
);

  // Whole state of the block
  typedef struct packed {
    logic [31:0] tag_outstanding_bits;
    logic [31:0] slot_issued_bits;
    logic [15:0] multiplier_port_notify_bits;
    logic port_run_control;
    logic [2:0] int_status;
    logic [2:0] int_mask;
    logic aw_held;
    logic [7:0] aw_addr;
    logic w_held;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } state_t;

  state_t state_q;
  state_t state_d;

  // Byte strobes widened to a bit mask
  function automatic logic [31:0] strb_mask(input logic [3:0] strb);
    logic [31:0] m;
    m = 32'h0000_0000;
    for (int i = 0; i < 4; i++) begin
      m[i*8 +: 8] = {8{strb[i]}};
    end
    return m;
  endfunction : strb_mask

  // True for an offset that holds a register
  function automatic logic addr_known(input logic [7:0] a);
    logic [7:0] w;
    w = {a[7:2], 2'b00};
    return (w == port_slot_pkg::OFS_INT_STATUS) || (w == port_slot_pkg::OFS_INT_MASK) ||
           (w == port_slot_pkg::OFS_PORT_CTRL) || (w == port_slot_pkg::OFS_QUEUED_ACTIVE) ||
           (w == port_slot_pkg::OFS_SLOT_ISSUE) || (w == port_slot_pkg::OFS_NOTIFY);
  endfunction : addr_known

  // Combinational helpers
  logic wr_do;            // Both halves of a write are held and the response slot is free
  logic [7:0] wr_word;    // Word-aligned write offset
  logic [31:0] wr_bits;   // Written ones under the byte strobes
  logic run_fall;         // Software moves run control from one to zero
  logic [31:0] active_set;
  logic [31:0] active_clr;
  logic [31:0] issue_set;
  logic [31:0] issue_clr;
  logic [15:0] notify_set;
  logic [15:0] notify_clr;
  logic [2:0] int_set;
  logic [2:0] int_clr;
  logic [7:0] rd_word;
  logic [31:0] rd_val;

  // Handshake outputs follow the held flags directly
  assign s_axi_awready_out = !state_q.aw_held && !state_q.bvalid;
  assign s_axi_wready_out = !state_q.w_held && !state_q.bvalid;
  assign s_axi_arready_out = !state_q.rvalid;
  assign s_axi_bvalid_out = state_q.bvalid;
  assign s_axi_bresp_out = state_q.bresp;
  assign s_axi_rvalid_out = state_q.rvalid;
  assign s_axi_rdata_out = state_q.rdata;
  assign s_axi_rresp_out = state_q.rresp;
  assign tag_outstanding_bits_out = state_q.tag_outstanding_bits;
  assign slot_issued_bits_out = state_q.slot_issued_bits;
  assign port_run_control_out = state_q.port_run_control;
  // Level interrupt while any unmasked status bit is set
  assign irq_out = |(state_q.int_status & state_q.int_mask);

  // Next-state logic for bus, registers and events
  always_comb begin
    state_d = state_q;
    wr_do = state_q.aw_held && state_q.w_held && !state_q.bvalid;
    wr_word = {state_q.aw_addr[7:2], 2'b00};
    wr_bits = state_q.w_data & strb_mask(state_q.w_strb);
    rd_word = {s_axi_araddr_in[7:2], 2'b00};
    // Run control falls only by a software write with bit 0 strobed low
    run_fall = wr_do && (wr_word == port_slot_pkg::OFS_PORT_CTRL) && state_q.w_strb[0] &&
               state_q.port_run_control && !state_q.w_data[port_slot_pkg::POS_RUN_CONTROL];
    // Software sets: zeros written leave bits alone
    active_set = (wr_do && wr_word == port_slot_pkg::OFS_QUEUED_ACTIVE) ? wr_bits : 32'h0000_0000;
    issue_set = (wr_do && wr_word == port_slot_pkg::OFS_SLOT_ISSUE) ? wr_bits : 32'h0000_0000;
    // Hardware clears from successful completion FIS
    active_clr = (sdb_valid_in && sdb_ok_in) ? sdb_sactive_in : 32'h0000_0000;
    issue_clr = 32'h0000_0000;
    if (slot_done_valid_in) begin
      issue_clr[slot_done_idx_in] = 1'b1;
    end
    // Notification from port 0 covers a directly attached device too
    notify_set = 16'h0000;
    if (sdb_valid_in && sdb_notify_in) begin
      notify_set[sdb_pm_port_in] = 1'b1;
    end
    // Only the low sixteen bits take a clear; upper bits are not stored
    notify_clr = (wr_do && wr_word == port_slot_pkg::OFS_NOTIFY) ?
                 wr_bits[port_slot_pkg::NOTIFY_W-1:0] : 16'h0000;
    // Interrupt events
    int_set = 3'h0;
    int_set[port_slot_pkg::INT_NOTIFY] = |notify_set;
    int_set[port_slot_pkg::INT_QUEUED_DONE] = |(active_clr & state_q.tag_outstanding_bits);
    int_set[port_slot_pkg::INT_SLOT_DONE] = |(issue_clr & state_q.slot_issued_bits);
    int_clr = (wr_do && wr_word == port_slot_pkg::OFS_INT_STATUS) ?
              wr_bits[port_slot_pkg::INT_W-1:0] : 3'h0;

    // Set wins over a clear in the same cycle
    state_d.tag_outstanding_bits = (state_q.tag_outstanding_bits & ~active_clr) | active_set;
    state_d.slot_issued_bits = (state_q.slot_issued_bits & ~issue_clr) | issue_set;
    if (run_fall) begin
      // Stopping the port drops every outstanding tag and issued slot
      state_d.tag_outstanding_bits = port_slot_pkg::RST_QUEUED_ACTIVE;
      state_d.slot_issued_bits = port_slot_pkg::RST_SLOT_ISSUE;
    end
    state_d.multiplier_port_notify_bits = (state_q.multiplier_port_notify_bits & ~notify_clr) | notify_set;
    state_d.int_status = (state_q.int_status & ~int_clr) | int_set;

    // Plain read-write control registers
    if (wr_do && wr_word == port_slot_pkg::OFS_PORT_CTRL && state_q.w_strb[0]) begin
      state_d.port_run_control = state_q.w_data[port_slot_pkg::POS_RUN_CONTROL];
    end
    if (wr_do && wr_word == port_slot_pkg::OFS_INT_MASK && state_q.w_strb[0]) begin
      state_d.int_mask = state_q.w_data[port_slot_pkg::INT_W-1:0];
    end

    // Write address and data are taken in either order
    if (s_axi_awvalid_in && s_axi_awready_out) begin
      state_d.aw_held = 1'b1;
      state_d.aw_addr = s_axi_awaddr_in;
    end
    if (s_axi_wvalid_in && s_axi_wready_out) begin
      state_d.w_held = 1'b1;
      state_d.w_data = s_axi_wdata_in;
      state_d.w_strb = s_axi_wstrb_in;
    end
    // Perform the write and raise the response
    if (wr_do) begin
      state_d.aw_held = 1'b0;
      state_d.w_held = 1'b0;
      state_d.bvalid = 1'b1;
      state_d.bresp = addr_known(state_q.aw_addr) ? port_slot_pkg::RESP_OKAY : port_slot_pkg::RESP_SLVERR;
    end else if (state_q.bvalid && s_axi_bready_in) begin
      state_d.bvalid = 1'b0;
    end

    // Read mux
    unique case (rd_word)
      port_slot_pkg::OFS_INT_STATUS: rd_val = {29'h0, state_q.int_status};
      port_slot_pkg::OFS_INT_MASK: rd_val = {29'h0, state_q.int_mask};
      port_slot_pkg::OFS_PORT_CTRL: rd_val = {31'h0, state_q.port_run_control};
      port_slot_pkg::OFS_QUEUED_ACTIVE: rd_val = state_q.tag_outstanding_bits;
      port_slot_pkg::OFS_SLOT_ISSUE: rd_val = state_q.slot_issued_bits;
      port_slot_pkg::OFS_NOTIFY: rd_val = {16'h0000, state_q.multiplier_port_notify_bits};
      default: rd_val = 32'h0000_0000;
    endcase
    if (s_axi_arvalid_in && s_axi_arready_out) begin
      state_d.rvalid = 1'b1;
      state_d.rdata = rd_val;
      state_d.rresp = addr_known(s_axi_araddr_in) ? port_slot_pkg::RESP_OKAY : port_slot_pkg::RESP_SLVERR;
    end else if (state_q.rvalid && s_axi_rready_in) begin
      state_d.rvalid = 1'b0;
    end
  end

  // State register; only the controller reset clears it
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      state_q <= '0;
      state_q.tag_outstanding_bits <= port_slot_pkg::RST_QUEUED_ACTIVE;
      state_q.slot_issued_bits <= port_slot_pkg::RST_SLOT_ISSUE;
      state_q.multiplier_port_notify_bits <= port_slot_pkg::RST_NOTIFY;
      state_q.int_status <= port_slot_pkg::RST_INT;
      state_q.int_mask <= port_slot_pkg::RST_INT;
    end else begin
      state_q <= state_d;
    end
  end

  // Checks
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (sys_rst_in);

  // Software sets land one cycle after the write is performed
  property p_active_w1s;
    wr_do && (wr_word == port_slot_pkg::OFS_QUEUED_ACTIVE) |=>
      ((state_q.tag_outstanding_bits & $past(wr_bits)) == $past(wr_bits));
  endproperty
  a_active_w1s: assert property (p_active_w1s) else $error("active bits not set by write");

  // Successful completion clears the reported tags unless set again
  property p_active_clear;
    sdb_valid_in && sdb_ok_in && (active_set == 32'h0000_0000) |=>
      ((state_q.tag_outstanding_bits & $past(sdb_sactive_in)) == 32'h0000_0000);
  endproperty
  a_active_clear: assert property (p_active_clear) else $error("completed tags still active");

  // A failed completion leaves the active bits standing
  property p_active_keep_on_error;
    sdb_valid_in && !sdb_ok_in && !run_fall |=>
      ((state_q.tag_outstanding_bits & $past(state_q.tag_outstanding_bits)) == $past(state_q.tag_outstanding_bits));
  endproperty
  a_active_keep_on_error: assert property (p_active_keep_on_error) else $error("active bit lost on error");

  // Stopping the port empties both slot registers at once
  property p_stop_clears;
    $fell(state_q.port_run_control) |-> (state_q.tag_outstanding_bits == 32'h0000_0000) &&
      (state_q.slot_issued_bits == 32'h0000_0000);
  endproperty
  a_stop_clears: assert property (p_stop_clears) else $error("slots not cleared on stop");

  // Issue writes set only, never clear
  property p_issue_w1s;
    wr_do && (wr_word == port_slot_pkg::OFS_SLOT_ISSUE) && !slot_done_valid_in |=>
      (state_q.slot_issued_bits == ($past(state_q.slot_issued_bits) | $past(wr_bits)));
  endproperty
  a_issue_w1s: assert property (p_issue_w1s) else $error("issue write not set-only");

  // Slot completion clears its issue bit
  property p_slot_done;
    slot_done_valid_in && (issue_set == 32'h0000_0000) && !run_fall |=>
      !state_q.slot_issued_bits[$past(slot_done_idx_in)];
  endproperty
  a_slot_done: assert property (p_slot_done) else $error("issue bit kept after completion");

  // Notification sets the bit of the sending port
  property p_notify_set;
    sdb_valid_in && sdb_notify_in |=> state_q.multiplier_port_notify_bits[$past(sdb_pm_port_in)];
  endproperty
  a_notify_set: assert property (p_notify_set) else $error("notification bit not set");

  // Writing ones clears notification bits when no event coincides
  property p_notify_w1c;
    (notify_clr != 16'h0000) && (notify_set == 16'h0000) |=>
      ((state_q.multiplier_port_notify_bits & $past(notify_clr)) == 16'h0000);
  endproperty
  a_notify_w1c: assert property (p_notify_w1c) else $error("notification bit not cleared");

  // Upper half of the notification register reads zero
  property p_notify_upper_zero;
    s_axi_arvalid_in && s_axi_arready_out && ({s_axi_araddr_in[7:2], 2'b00} == port_slot_pkg::OFS_NOTIFY) |=>
      s_axi_rvalid_out && (s_axi_rdata_out[31:16] == 16'h0000);
  endproperty
  a_notify_upper_zero: assert property (p_notify_upper_zero) else $error("notification upper bits nonzero");

  // Write response follows the performed write by one cycle
  property p_write_resp;
    wr_do |=> s_axi_bvalid_out ##0 !state_q.aw_held ##0 !state_q.w_held;
  endproperty
  a_write_resp: assert property (p_write_resp) else $error("write response missing");

  // Issue bits only drop by a slot completion or a stop
  property p_issue_keep;
    (issue_clr == 32'h0000_0000) && !run_fall |=>
      ((state_q.slot_issued_bits & $past(state_q.slot_issued_bits)) == $past(state_q.slot_issued_bits));
  endproperty
  a_issue_keep: assert property (p_issue_keep) else $error("issue bit lost without completion");

  // Notification bits drop only by a software clear or the controller reset
  property p_notify_keep;
    (notify_clr == 16'h0000) |=>
      ((state_q.multiplier_port_notify_bits & $past(state_q.multiplier_port_notify_bits)) ==
       $past(state_q.multiplier_port_notify_bits));
  endproperty
  a_notify_keep: assert property (p_notify_keep) else $error("notification bit lost");

  // An enabled notification raises the interrupt on the next cycle
  property p_notify_irq;
    sdb_valid_in && sdb_notify_in && state_q.int_mask[port_slot_pkg::INT_NOTIFY] &&
      !(wr_do && (wr_word == port_slot_pkg::OFS_INT_MASK)) |=> irq_out;
  endproperty
  a_notify_irq: assert property (p_notify_irq) else $error("notification did not raise interrupt");

  // Main scenarios
  c_queued_done: cover property (sdb_valid_in && sdb_ok_in && |(sdb_sactive_in & state_q.tag_outstanding_bits));
  c_stop: cover property ($fell(state_q.port_run_control) ##1 state_q.port_run_control);
  c_notify_irq: cover property (sdb_valid_in && sdb_notify_in ##1 irq_out);
  c_slot_done: cover property (slot_done_valid_in && |state_q.slot_issued_bits);
  c_notify_clear: cover property (notify_clr != 16'h0000);

endmodule : port_cmd_issue_active_notify

`default_nettype wire

/* inc/port_slot_pkg.sv */
// Constants for the per-port slot issue, queued-active and notification registers
package port_slot_pkg;
  // Bus geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  // Register byte offsets
  localparam logic [7:0] OFS_INT_STATUS = 8'h10;
  localparam logic [7:0] OFS_INT_MASK = 8'h14;
  localparam logic [7:0] OFS_PORT_CTRL = 8'h18;
  localparam logic [7:0] OFS_QUEUED_ACTIVE = 8'h34;
  localparam logic [7:0] OFS_SLOT_ISSUE = 8'h38;
  localparam logic [7:0] OFS_NOTIFY = 8'h3C;
  // Values after reset
  localparam logic [31:0] RST_QUEUED_ACTIVE = 32'h0000_0000;
  localparam logic [31:0] RST_SLOT_ISSUE = 32'h0000_0000;
  localparam logic [15:0] RST_NOTIFY = 16'h0000;
  localparam logic [2:0] RST_INT = 3'h0;
  // Field positions
  localparam int POS_RUN_CONTROL = 0;
  localparam int NOTIFY_W = 16;
  localparam int INT_W = 3;
  localparam int INT_NOTIFY = 0;
  localparam int INT_QUEUED_DONE = 1;
  localparam int INT_SLOT_DONE = 2;
  // Bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : port_slot_pkg

/* sim/link_device_model.sv */
// Storage device model that sends received-FIS events to the port
`timescale 1ns/1ps
`default_nettype none

module link_device_model (
  input wire logic clk_in,
  output logic sdb_valid_out,
  output logic [31:0] sdb_sactive_out,
  output logic sdb_ok_out,
  output logic sdb_notify_out,
  output logic [3:0] sdb_pm_port_out,
  output logic done_valid_out,
  output logic [4:0] done_idx_out
);
  // Quiet link until the first frame
  initial begin
    sdb_valid_out = 1'b0;
    sdb_sactive_out = 32'h0;
    sdb_ok_out = 1'b0;
    sdb_notify_out = 1'b0;
    sdb_pm_port_out = 4'h0;
    done_valid_out = 1'b0;
    done_idx_out = 5'h0;
  end

  // One set-device-bits frame; the fields go stale (inverted) once the strobe drops
  task automatic send_sdb(input logic [31:0] act, input logic ok, input logic ntf, input logic [3:0] pmp);
    @(posedge clk_in);
    sdb_valid_out <= 1'b1;
    sdb_sactive_out <= act;
    sdb_ok_out <= ok;
    sdb_notify_out <= ntf;
    sdb_pm_port_out <= pmp;
    @(posedge clk_in);
    sdb_valid_out <= 1'b0;
    sdb_sactive_out <= ~act;
    sdb_ok_out <= ~ok;
    sdb_notify_out <= ~ntf;
    sdb_pm_port_out <= ~pmp;
  endtask : send_sdb

  // One status frame that clears busy, data request and error for a slot
  task automatic send_done(input logic [4:0] idx);
    @(posedge clk_in);
    done_valid_out <= 1'b1;
    done_idx_out <= idx;
    @(posedge clk_in);
    done_valid_out <= 1'b0;
    done_idx_out <= ~idx;
  endtask : send_done
endmodule : link_device_model
`default_nettype wire

/* sim/tb.sv */
// Self-checking bench for the port slot registers
`timescale 1ns/1ps
`default_nettype none

module tb;
  logic clk = 1'b0, rst = 1'b1;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [7:0] awaddr = 8'h0, araddr = 8'h0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hF;
  logic awready, wready, bvalid, arready, rvalid, irq, run, sv, sok, sntf, dv;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata, act, iss, sact;
  logic [3:0] spmp;
  logic [4:0] didx;
  int fail_count = 0, cmp_count = 0;

  // 25 MHz clock
  always #20 clk = ~clk;

  port_cmd_issue_active_notify DUT (.clk_in(clk), .sys_rst_in(rst),
    .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready), .s_axi_awaddr_in(awaddr),
    .s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready), .s_axi_wdata_in(wdata), .s_axi_wstrb_in(wstrb),
    .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready), .s_axi_bresp_out(bresp),
    .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready), .s_axi_araddr_in(araddr),
    .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready), .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp),
    .sdb_valid_in(sv), .sdb_sactive_in(sact), .sdb_ok_in(sok), .sdb_notify_in(sntf), .sdb_pm_port_in(spmp),
    .slot_done_valid_in(dv), .slot_done_idx_in(didx), .tag_outstanding_bits_out(act),
    .slot_issued_bits_out(iss), .port_run_control_out(run), .irq_out(irq));

  link_device_model dev (.clk_in(clk), .sdb_valid_out(sv), .sdb_sactive_out(sact), .sdb_ok_out(sok),
    .sdb_notify_out(sntf), .sdb_pm_port_out(spmp), .done_valid_out(dv), .done_idx_out(didx));

  // Verdict and end of run
  task automatic close_out();
    if (fail_count == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : close_out

  // Compare one value with its expectation
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask : check

  // A wait that ran out ends the run
  task automatic hang(input int n);
    if (n > 50) begin
      fail_count++;
      $display("Error at %0t: no bus answer", $time);
      close_out();
    end
  endtask : hang

  // One bus write; channels released at the edge that takes them
  task automatic wr_raw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] resp);
    int n;
    logic aw_hit, w_hit, b_hit;
    n = 0;
    @(posedge clk);
    awvalid <= 1'b1;
    awaddr <= a;
    wvalid <= 1'b1;
    wdata <= d;
    bready <= 1'b1;
    do begin
      #1;
      aw_hit = awvalid && awready;
      w_hit = wvalid && wready;
      b_hit = bvalid;
      resp = bresp;
      @(posedge clk);
      if (aw_hit) awvalid <= 1'b0;
      if (w_hit) wvalid <= 1'b0;
      n++;
      hang(n);
    end while (!b_hit);
    bready <= 1'b0;
  endtask : wr_raw

  // One bus read; data taken at the edge with rvalid high
  task automatic rd_raw(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
    int n;
    logic ar_hit, r_hit;
    n = 0;
    @(posedge clk);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    do begin
      #1;
      ar_hit = arvalid && arready;
      r_hit = rvalid;
      d = rdata;
      resp = rresp;
      @(posedge clk);
      if (ar_hit) arvalid <= 1'b0;
      n++;
      hang(n);
    end while (!r_hit);
    rready <= 1'b0;
  endtask : rd_raw

  // Mapped write that must be accepted
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    wr_raw(a, d, r);
    check({30'h0, r}, {30'h0, port_slot_pkg::RESP_OKAY});
  endtask : wr

  // Mapped read compared with an expected word
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0] r;
    rd_raw(a, d, r);
    check(d, exp);
    check({30'h0, r}, {30'h0, port_slot_pkg::RESP_OKAY});
  endtask : rd_chk

  // Set-only writes: zeros leave bits alone, active set before issue
  task automatic t_set_only();
    wr(8'h18, 32'h0000_0001);
    #1 check({31'h0, run}, 32'h1);
    wr(8'h34, 32'h0000_0005);
    wr(8'h34, 32'h0000_0002);
    wr(8'h34, 32'h0000_0000);
    rd_chk(8'h34, 32'h0000_0007);
    #1 check(act, 32'h0000_0007);
    wr(8'h38, 32'h8000_0001);
    wr(8'h38, 32'h0000_0000);
    rd_chk(8'h38, 32'h8000_0001);
  endtask : t_set_only

  // Link completions: slot done, failed and good queued completions
  task automatic t_completion();
    dev.send_done(5'h1F);
    #1 check(iss, 32'h0000_0001);
    dev.send_sdb(32'h0000_0005, 1'b0, 1'b0, 4'h0);
    #1 check(act, 32'h0000_0007);
    dev.send_sdb(32'h0000_0005, 1'b1, 1'b0, 4'h0);
    #1 check(act, 32'h0000_0002);
  endtask : t_completion

  // Notification from every port, clearing, interrupt raise and clear
  task automatic t_notify();
    wr(8'h14, 32'h0000_0001);
    for (int p = 0; p < 16; p++) dev.send_sdb(32'h0, 1'b1, 1'b1, p[3:0]);
    rd_chk(8'h3C, 32'h0000_FFFF);
    @(posedge clk);
    #1 check({31'h0, irq}, 32'h1);
    wr(8'h3C, 32'hFFFF_00FF);
    rd_chk(8'h3C, 32'h0000_FF00);
    wr(8'h14, 32'h0000_0000);
    @(posedge clk);
    #1 check({31'h0, irq}, 32'h0);
    wr(8'h14, 32'h0000_0001);
    wr(8'h10, 32'h0000_0001);
    @(posedge clk);
    #1 check({31'h0, irq}, 32'h0);
  endtask : t_notify

  // Stopping the port empties active and issue, keeps notifications
  task automatic t_stop();
    // A control write with the low byte unstrobed must not stop the port
    @(posedge clk);
    wstrb <= 4'hE;
    wr(8'h18, 32'h0000_0000);
    wstrb <= 4'hF;
    #1 check({31'h0, run}, 32'h1);
    check(act, 32'h0000_0002);
    check(iss, 32'h0000_0001);
    wr(8'h18, 32'h0000_0000);
    #1 check(act, 32'h0);
    check(iss, 32'h0);
    check({31'h0, run}, 32'h0);
    rd_chk(8'h3C, 32'h0000_FF00);
  endtask : t_stop

  // Unmapped place answers with an error and reads zero
  task automatic t_unmapped();
    logic [31:0] d;
    logic [1:0] r;
    wr_raw(8'h40, 32'h1234_5678, r);
    check({30'h0, r}, {30'h0, port_slot_pkg::RESP_SLVERR});
    rd_raw(8'h40, d, r);
    check(d, 32'h0);
    check({30'h0, r}, {30'h0, port_slot_pkg::RESP_SLVERR});
  endtask : t_unmapped

  // Main sequence, with a controller reset after the last test
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    rd_chk(8'h34, 32'h0);
    rd_chk(8'h38, 32'h0);
    rd_chk(8'h3C, 32'h0);
    t_set_only();
    t_completion();
    t_notify();
    t_stop();
    t_unmapped();
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rd_chk(8'h3C, 32'h0);
    close_out();
  end
endmodule : tb
`default_nettype wire
